// *** include/hseq_pkg.sv ***
// Package: homing sequencer constants and types
package hseq_pkg;
   localparam logic [31:0] PPR_RESET = 32'h0000_2710;
   localparam logic [31:0] NUM_RESET = 32'h0000_0001;
   localparam logic [7:0] METHOD_RESET = 8'h13;
   localparam logic [7:0] EDGE_BASE = 8'h10;
   localparam logic [7:0] M_NEG_INDEX = 8'h21;
   localparam logic [7:0] M_POS_INDEX = 8'h22;
   localparam logic [7:0] M_HERE_LO = 8'h23;
   localparam logic [7:0] M_HERE_HI = 8'h25;

   typedef enum logic [1:0] {SRC_NLIM, SRC_PLIM, SRC_HOME, SRC_NONE} hseq_src_t;

   typedef struct packed {
      logic valid;
      logic dir_pos;
      hseq_src_t src;
      logic rise;
      logic far_side;
      logic use_index;
      logic here;
   } hseq_plan_t;

   typedef struct packed {
      logic neg_limit;
      logic pos_limit;
      logic home_sw;
      logic index;
   } hseq_pins_t;
endpackage

// *** src/hseq_top.sv ***
// Homing search sequencer with electronic gear ratio selection
`timescale 1ns/1ps
module hseq_top
   import hseq_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   input wire logic I_PPR_WE,
   input wire logic [31:0] I_PPR_DATA,
   input wire logic [31:0] I_GEAR_NUM,
   input wire logic [31:0] I_ENC_RES,
   input wire logic [7:0] I_METHOD,
   input wire logic I_START,
   input wire logic I_ABORT,
   input wire logic [31:0] I_POSITION,
   input wire logic I_NEG_LIMIT,
   input wire logic I_POS_LIMIT,
   input wire logic I_HOME_SW,
   input wire logic I_INDEX,
   output logic [31:0] O_PPR,
   output logic [31:0] O_RATIO_NUM,
   output logic [31:0] O_RATIO_DEN,
   output logic O_MOVING,
   output logic O_DIR_POS,
   output logic O_SLOW,
   output logic O_DONE,
   output logic O_ERROR,
   output logic O_HOME_STROBE,
   output logic [31:0] O_HOME_POS
);
   typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_EDGE, ST_INDEX, ST_DONE} hseq_state_t;

   // Method table; edge methods reuse the base pattern
   function automatic hseq_plan_t decode(input logic [7:0] m);
      hseq_plan_t p;
      logic [7:0] b;
      p = '0;
      b = (m > EDGE_BASE && m <= 8'h20) ? m - EDGE_BASE : m;
      p.use_index = (m <= 8'h0e);
      p.valid = 1'b1;
      case (b)
         8'h01: begin p.src = SRC_NLIM; end
         8'h02: begin p.src = SRC_PLIM; p.dir_pos = 1'b1; end
         8'h03, 8'h07, 8'h0a: begin p.src = SRC_HOME; p.dir_pos = 1'b1; end
         8'h04, 8'h08, 8'h09: begin
            p.src = SRC_HOME;
            p.dir_pos = 1'b1;
            p.rise = 1'b1;
         end
         8'h05, 8'h0b: begin p.src = SRC_HOME; end
         8'h06, 8'h0c: begin p.src = SRC_HOME; p.rise = 1'b1; end
         8'h0d: begin p.src = SRC_HOME; p.rise = 1'b1; p.far_side = 1'b1; end
         8'h0e: begin p.src = SRC_HOME; p.far_side = 1'b1; end
         default: begin
            p.src = SRC_NONE;
            if (m == M_NEG_INDEX || m == M_POS_INDEX) begin
               p.use_index = 1'b1;
               p.dir_pos = (m == M_POS_INDEX);
            end else if (m >= M_HERE_LO && m <= M_HERE_HI) begin
               p.here = 1'b1;
            end else begin
               p.valid = 1'b0;
            end
         end
      endcase
      return p;
   endfunction

   hseq_pins_t s1_q, s2_q, prev_q;
   hseq_state_t st_q;
   hseq_plan_t plan_q;
   logic [31:0] ppr_q;
   logic seen_q;
   logic moving_q, dir_q, slow_q, done_q, err_q, strobe_q;
   logic [31:0] home_q;
   logic [31:0] ratio_q;

   // Pins cross two stages before any logic looks at them
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s1_q <= '0;
         s2_q <= '0;
         prev_q <= '0;
      end else if (I_CE) begin
         s1_q <= {I_NEG_LIMIT, I_POS_LIMIT, I_HOME_SW, I_INDEX};
         s2_q <= s1_q;
         prev_q <= s2_q;
      end
   end

   wire hseq_plan_t plan_in = decode(I_METHOD);
   wire sw_now = (plan_q.src == SRC_NLIM) ? s2_q.neg_limit :
                 (plan_q.src == SRC_PLIM) ? s2_q.pos_limit : s2_q.home_sw;
   wire sw_old = (plan_q.src == SRC_NLIM) ? prev_q.neg_limit :
                 (plan_q.src == SRC_PLIM) ? prev_q.pos_limit : prev_q.home_sw;
   wire sw_rise = sw_now && !sw_old;
   wire sw_fall = !sw_now && sw_old;
   wire want_edge = plan_q.rise ? sw_rise : sw_fall;
   wire index_rise = s2_q.index && !prev_q.index;
   // Limit methods use the limit falling edge
   wire is_limit = (plan_q.src == SRC_NLIM) || (plan_q.src == SRC_PLIM);
   wire edge_hit = is_limit ? sw_fall : want_edge;
   // Far-side methods need the switch crossed once before the counted edge
   wire far_ok = !plan_q.far_side || seen_q;
   wire edge_ok = edge_hit && far_ok;

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ppr_q <= PPR_RESET;
      end else if (I_CE && I_PPR_WE && I_PPR_DATA != 32'h0000_0000) begin
         ppr_q <= I_PPR_DATA;
      end
   end

   wire [31:0] ratio_sel = (ppr_q != I_ENC_RES) ? I_ENC_RES : I_GEAR_NUM;

   // Registered data output; follows a setting change one clock later
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ratio_q <= NUM_RESET;
      end else if (I_CE) begin
         ratio_q <= ratio_sel;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q <= ST_IDLE;
         plan_q <= '0;
         seen_q <= 1'b0;
         moving_q <= 1'b0;
         dir_q <= 1'b0;
         slow_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         strobe_q <= 1'b0;
         home_q <= '0;
      end else if (I_CE) begin
         strobe_q <= 1'b0;
         if (I_ABORT && st_q != ST_IDLE) begin
            st_q <= ST_IDLE;
            moving_q <= 1'b0;
            slow_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  if (I_START) begin
                     plan_q <= plan_in;
                     seen_q <= 1'b0;
                     done_q <= 1'b0;
                     err_q <= !plan_in.valid;
                     slow_q <= 1'b0;
                     dir_q <= plan_in.dir_pos;
                     if (!plan_in.valid) begin
                        st_q <= ST_IDLE;
                     end else if (plan_in.here) begin
                        home_q <= I_POSITION;
                        strobe_q <= 1'b1;
                        st_q <= ST_DONE;
                     end else begin
                        moving_q <= 1'b1;
                        st_q <= (plan_in.src == SRC_NONE) ? ST_INDEX : ST_SEEK;
                     end
                  end
               end
               ST_SEEK: begin
                  if (sw_now) begin
                     slow_q <= 1'b1;
                     st_q <= ST_EDGE;
                     // Rising-edge methods other than far-side ones meet their edge on the way in
                     if (edge_ok && plan_q.use_index) begin
                        st_q <= ST_INDEX;
                     end else if (edge_ok) begin
                        home_q <= I_POSITION;
                        strobe_q <= 1'b1;
                        moving_q <= 1'b0;
                        st_q <= ST_DONE;
                     end
                  end
               end
               ST_EDGE: begin
                  if (plan_q.far_side && sw_fall && !seen_q) begin
                     seen_q <= 1'b1;
                  end
                  if (edge_ok) begin
                     if (plan_q.use_index) begin
                        st_q <= ST_INDEX;
                     end else begin
                        home_q <= I_POSITION;
                        strobe_q <= 1'b1;
                        moving_q <= 1'b0;
                        st_q <= ST_DONE;
                     end
                  end
               end
               ST_INDEX: begin
                  if (index_rise) begin
                     home_q <= I_POSITION;
                     strobe_q <= 1'b1;
                     moving_q <= 1'b0;
                     st_q <= ST_DONE;
                  end
               end
               ST_DONE: begin
                  done_q <= 1'b1;
                  slow_q <= 1'b0;
                  st_q <= ST_IDLE;
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign O_PPR = ppr_q;
   assign O_RATIO_NUM = ratio_q;
   assign O_RATIO_DEN = ppr_q;
   assign O_MOVING = moving_q;
   assign O_DIR_POS = dir_q;
   assign O_SLOW = slow_q;
   assign O_DONE = done_q;
   assign O_ERROR = err_q;
   assign O_HOME_STROBE = strobe_q;
   assign O_HOME_POS = home_q;

   ppr_floor_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      ppr_q != 32'h0000_0000) else $error("ppr zero");
   ratio_sel_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ppr_q == I_ENC_RES) |=> O_RATIO_NUM == $past(I_GEAR_NUM))
      else $error("ratio num");
   ratio_enc_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ppr_q != I_ENC_RES) |=> O_RATIO_NUM == $past(I_ENC_RES))
      else $error("ratio enc");
   here_home_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && st_q == ST_IDLE && I_START && plan_in.here && plan_in.valid)
      |=> strobe_q && !moving_q && home_q == $past(I_POSITION)) else $error("here");
   index_home_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && !I_ABORT && st_q == ST_INDEX && index_rise) |=> strobe_q && st_q == ST_DONE)
      else $error("index home");
   edge_home_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && !I_ABORT && st_q == ST_EDGE && edge_ok && !plan_q.use_index)
      |=> strobe_q) else $error("edge home");
   slow_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && !I_ABORT && st_q == ST_SEEK && sw_now) |=> slow_q) else $error("slow");
   dir_neg_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && st_q == ST_IDLE && I_START && I_METHOD == M_NEG_INDEX) |=> !dir_q)
      else $error("dir 33");
endmodule

// *** testbench/hseq_axis_model.sv ***
// Axis model: position, limit switches, homing cams and encoder index
`timescale 1ns/1ps
module hseq_axis_model
   import hseq_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_moving,
   input wire logic i_dir_pos,
   input wire logic i_load,
   input wire logic [31:0] i_load_val,
   input wire logic [3:0] i_period,
   output hseq_pins_t o_pins,
   output logic [31:0] o_pos
);
   logic [3:0] cnt_q;
   int p;
   int cam;
   always_comb begin
      p = $signed(o_pos);
      cam = ((p % 40) + 40) % 40;
      o_pins.neg_limit = (p <= -100) && (p >= -109);
      o_pins.pos_limit = (p >= 100) && (p <= 109);
      // Repeating cams so far-side searches meet a second edge
      o_pins.home_sw = (cam >= 20) && (cam <= 29);
      o_pins.index = (o_pos[2:0] == 3'h0);
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 4'h0;
         o_pos <= 32'h0;
      end else if (i_load) begin
         cnt_q <= 4'h0;
         o_pos <= i_load_val;
      end else if (i_moving) begin
         // Steps outlast the pin latency, so the captured position is settled
         cnt_q <= (cnt_q == i_period) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q == i_period) begin
            o_pos <= i_dir_pos ? o_pos + 32'h1 : o_pos - 32'h1;
         end
      end
   end
endmodule

// *** testbench/tb_top.sv ***
// Testbench for the homing sequencer
`timescale 1ns/1ps
module tb_top;
   import hseq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1, we = 1'b0, start = 1'b0, abort = 1'b0, load = 1'b0;
   logic [31:0] wdata = 32'h0, gear = 32'h7, enc = 32'h2710, lval = 32'h0;
   logic [7:0] method = 8'h0;
   logic [3:0] period = 4'h7;
   logic [31:0] ppr, rnum, rden, hpos, pos;
   logic moving, dir_pos, slow, done, err, strobe;
   hseq_pins_t pins;
   int n_mismatch = 0;
   int n_tests = 0;
   int ip [14] = '{-112, 112, 32, 24, -24, -16, 32, 24, 24, 32, -24, -16, -56, -64};
   int ep [14] = '{-110, 110, 30, 20, -21, -11, 30, 20, 20, 30, -21, -11, -51, -61};
   logic [13:0] dp = 14'h03ce;
   always #2 clk = ~clk;
   hseq_top u_hseq_top (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PPR_WE(we),
      .I_PPR_DATA(wdata), .I_GEAR_NUM(gear), .I_ENC_RES(enc), .I_METHOD(method),
      .I_START(start), .I_ABORT(abort), .I_POSITION(pos), .I_NEG_LIMIT(pins.neg_limit),
      .I_POS_LIMIT(pins.pos_limit), .I_HOME_SW(pins.home_sw), .I_INDEX(pins.index),
      .O_PPR(ppr), .O_RATIO_NUM(rnum), .O_RATIO_DEN(rden), .O_MOVING(moving),
      .O_DIR_POS(dir_pos), .O_SLOW(slow), .O_DONE(done), .O_ERROR(err),
      .O_HOME_STROBE(strobe), .O_HOME_POS(hpos));
   hseq_axis_model u_hseq_axis_model (.i_clock(clk), .i_rst_n(rst_n), .i_moving(moving),
      .i_dir_pos(dir_pos), .i_load(load), .i_load_val(lval), .i_period(period),
      .o_pins(pins), .o_pos(pos));
   task automatic results();
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wppr(input logic [31:0] v);
      wdata = v;
      we = 1'b1;
      tick(1);
      we = 1'b0;
      tick(1);
   endtask
   task automatic run(input logic [7:0] m, input logic dir, input logic [31:0] exp,
                      input logic [3:0] per);
      int i;
      int n_str;
      logic saw_slow;
      period = per;
      method = m;
      // Position jumps only while stopped; pin stages settle before start
      load = 1'b1;
      tick(1);
      load = 1'b0;
      tick(4);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      n_str = (strobe === 1'b1) ? 1 : 0;
      saw_slow = 1'b0;
      if (m < M_HERE_LO) begin
         check("moving", {31'h0, moving}, 32'h1);
         check("direction", {31'h0, dir_pos}, {31'h0, dir});
      end
      for (i = 0; i < 4000 && done !== 1'b1; i++) begin
         tick(1);
         if (strobe === 1'b1) n_str++;
         if (slow === 1'b1) saw_slow = 1'b1;
      end
      if (done !== 1'b1) begin
         n_mismatch++;
         results();
      end else begin
         check("home position", hpos, exp);
         check("home strobes", 32'(n_str), 32'h1);
         check("moving after home", {31'h0, moving}, 32'h0);
         check("slow seen", {31'h0, saw_slow}, {31'h0, m < M_NEG_INDEX});
         check("slow after home", {31'h0, slow}, 32'h0);
      end
   endtask
   task automatic error_test(input logic [7:0] m);
      method = m;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(1);
      check("error flag", {31'h0, err}, 32'h1);
      check("error moving", {31'h0, moving}, 32'h0);
   endtask
   task automatic abort_test();
      method = 8'h02;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      check("error cleared", {31'h0, err}, 32'h0);
      tick(20);
      abort = 1'b1;
      tick(1);
      abort = 1'b0;
      tick(2);
      check("abort moving", {31'h0, moving}, 32'h0);
      check("abort slow", {31'h0, slow}, 32'h0);
   endtask
   task automatic ratio_test();
      check("ppr reset", ppr, PPR_RESET);
      tick(1);
      check("ratio num", rnum, 32'h7);
      check("ratio den", rden, 32'h2710);
      enc = 32'h0002_0000;
      tick(1);
      check("ratio num", rnum, 32'h0002_0000);
      check("ratio den", rden, 32'h2710);
      wppr(32'h0);
      check("ppr zero write", ppr, 32'h2710);
      wppr(32'h1);
      check("ppr", ppr, 32'h1);
      check("ratio num", rnum, 32'h0002_0000);
      enc = 32'h1;
      tick(1);
      check("ratio num", rnum, 32'h7);
      check("ratio den", rden, 32'h1);
      // Clock enable low must freeze the setting
      ce = 1'b0;
      wppr(32'h5);
      ce = 1'b1;
      check("ppr frozen", ppr, 32'h1);
   endtask
   initial begin
      int k;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      ratio_test();
      for (k = 0; k < 14; k++) begin
         run(8'(k + 1), dp[k], 32'(ip[k]), 4'h7);
         run(8'(k + 17), dp[k], 32'(ep[k]), 4'hb);
      end
      run(8'h21, 1'b0, 32'hffff_fff8, 4'h7);
      run(8'h22, 1'b1, 32'h8, 4'h7);
      lval = 32'h0000_0abc;
      for (k = 35; k < 38; k++) run(8'(k), 1'b0, 32'h0000_0abc, 4'h7);
      error_test(8'h1f);
      error_test(8'h26);
      // Abort in mid-search must stop the axis
      abort_test();
      results();
   end
endmodule
